// ### src/ndx_exchange.sv
/*
 * Shared memory image and network exchange of a master/slave drop module.
 * Assumes a host port of single-cycle accesses and a word-level link whose
 * far end runs on the same clock; straps arrive asynchronously on pins.
 */
// Operation
// - Depth valid only from 1 up to 56 minus own drop setting.
// - In master mode the depth register has no effect.
// - Bit 14 flags the depth value currently held as invalid; the code never sets it in master mode.
// - While invalid, the last valid depth keeps being used.
// - Bit 15 is set once the written depth has been processed.
// - Depth change never disturbs the drop currently being served.
// - Before depth is defined only the physical drop area is served.
// - Master sends broadcast words with every drop-area update.
// - Broadcast words writable by host in master, read-only in slave.
// - Areas 1-55 each hold 64 sixteen-bit words.
// - Slave host writes lower 32 words only in areas it owns.
// - Upper 32 words writable only in master, sent to addressed drop.
// - All active modules keep identical broadcast and area images.
// - Written data reaches other images within one update period.
// - Update period is drop time per drop plus probe and message time.
// - Each drop update moves all 32 words each way.
// - Master probes one inactive drop per update cycle and waits.
// - Drop setting captured once after reset into a readable word.
`timescale 1ns/1ps
module ndx_exchange import ndx_pkg::*; #(
	parameter int DROP_WAIT  = DROP_CYCLES,
	parameter int PROBE_WAIT = NEW_DROP_CYCLES,
	parameter int MSG_WAIT   = MSG_MASTER_CYCLES
) (
	input  wire logic                  clock,
	input  wire logic                  rst_n,
	input  wire logic                  master_pin,
	input  wire logic [5:0]            drop_switch,
	input  wire logic                  term_msg,
	input  wire logic                  host_en,
	input  wire logic                  host_we,
	input  wire logic [NDX_ADDR_W-1:0] host_addr,
	input  wire logic [NDX_DATA_W-1:0] host_wdata,
	output logic [NDX_DATA_W-1:0]      host_rdata,
	output logic                       host_ack,
	output logic                       host_refused,
	input  wire logic                  rx_valid,
	input  wire logic                  rx_poll,
	input  wire logic [NDX_ADDR_W-1:0] rx_addr,
	input  wire logic [NDX_DATA_W-1:0] rx_data,
	output logic                       tx_valid,
	input  wire logic                  tx_ready,
	output logic                       tx_poll,
	output logic [NDX_ADDR_W-1:0]      tx_addr,
	output logic [NDX_DATA_W-1:0]      tx_data
);

	typedef struct packed {
		logic                                 msync1;
		logic                                 msync2;
		logic [5:0]                           dsync1;
		logic [5:0]                           dsync2;
		logic [1:0]                           boot;
		logic                                 captured;
		logic                                 is_master;
		logic [5:0]                           own_drop;
		logic [DEPTH_VAL_W-1:0]               depth_raw;
		logic                                 depth_err;
		logic                                 depth_done;
		logic                                 depth_pend;
		logic [5:0]                           depth_act;
		logic                                 depth_def;
		ndx_state_t                           st;
		logic [5:0]                           drop;
		logic [5:0]                           idx;
		logic [TIMER_W-1:0]                   timer;
		logic [5:0]                           last_probe;
		logic                                 probed;
		logic                                 msg_wait;
		logic [NDX_DROPS-1:0]                 active;
		logic [NDX_DROPS-1:0]                 heard;
		logic                                 seq_valid;
		logic [TX_W-1:0]                      seq_word;
		logic [NDX_DATA_W-1:0]                rd_data;
		logic                                 ack;
		logic                                 refused;
		logic [NDX_WORDS-1:0][NDX_DATA_W-1:0] mem;
	} ndx_state_reg_t;

	ndx_state_reg_t r_reg;
	ndx_state_reg_t r_next;
	logic           buf_ready;
	logic [TX_W-1:0] buf_word;

	// Drop d is served by this slave; an undefined depth covers the physical drop only
	function automatic logic owned(input logic [5:0] d, input logic [5:0] own,
			input logic [5:0] act, input logic def);
		logic [6:0] top;
		top = {1'b0, own} + {1'b0, (def ? act : 6'h01)};
		owned = (d >= own) && ({1'b0, d} < top);
	endfunction

	function automatic logic [11:0] word_index(input logic [5:0] area, input logic [5:0] rg);
		word_index = {area, rg};
	endfunction

	always_comb begin
		logic [5:0]  h_area;
		logic [5:0]  h_reg;
		logic [5:0]  x_area;
		logic [5:0]  x_reg;
		logic [5:0]  w_area;
		logic [5:0]  w_reg;
		logic        last;
		logic        probe;
		logic        x_hit;
		logic [13:0] limit;
		h_area = host_addr[11:6];
		h_reg  = host_addr[5:0];
		x_area = rx_addr[11:6];
		x_reg  = rx_addr[5:0];
		w_area = 6'h00;
		w_reg  = 6'h00;
		last   = 1'b0;
		probe  = r_reg.active[r_reg.drop] == 1'b0;
		x_hit  = 1'b0;
		limit  = DROP_LIMIT - {8'h00, r_reg.own_drop};
		r_next = r_reg;
		r_next.ack     = 1'b0;
		r_next.refused = 1'b0;

		// Pin synchronisers and one-time strap capture
		r_next.msync1 = master_pin;
		r_next.msync2 = r_reg.msync1;
		r_next.dsync1 = drop_switch;
		r_next.dsync2 = r_reg.dsync1;
		if (r_reg.boot != BOOT_DONE) begin
			r_next.boot = r_reg.boot + 2'h1;
		end else if (!r_reg.captured) begin
			r_next.captured  = 1'b1;
			r_next.is_master = r_reg.msync2;
			r_next.own_drop  = r_reg.dsync2;
		end

		// Pending depth check
		if (r_reg.depth_pend) begin
			r_next.depth_pend = 1'b0;
			r_next.depth_done = 1'b1;
			if (r_reg.depth_raw >= DEPTH_MIN && r_reg.depth_raw <= limit) begin
				r_next.depth_act = r_reg.depth_raw[5:0];
				r_next.depth_def = 1'b1;
				r_next.depth_err = 1'b0;
			end else begin
				r_next.depth_err = 1'b1;
			end
		end

		// Words arriving from the link
		if (rx_valid && !rx_poll && x_area <= NDX_LAST_DROP) begin
			if (r_reg.is_master) begin
				x_hit = x_area != 6'h00 && x_reg <= SLAVE_LAST_IDX;
				if (x_hit) begin
					r_next.heard[x_area] = 1'b1;
				end
			end else if (x_area == 6'h00) begin
				x_hit = x_reg >= REG_BCAST_FIRST && x_reg <= REG_BCAST_LAST;
			end else begin
				x_hit = !(x_reg <= SLAVE_LAST_IDX && owned(x_area, r_reg.own_drop,
					r_reg.depth_act, r_reg.depth_def));
			end
			if (x_hit) begin
				r_next.mem[word_index(x_area, x_reg)] = rx_data;
			end
		end

		// Host port
		if (host_en) begin
			r_next.ack = 1'b1;
			if (!host_we) begin
				if (h_area == 6'h00 && h_reg == REG_DROP_NUMBER) begin
					r_next.rd_data = {10'h000, r_reg.own_drop};
				end else if (h_area == 6'h00 && h_reg == REG_DROP_DEPTH) begin
					r_next.rd_data = {r_reg.depth_done, r_reg.depth_err, r_reg.depth_raw};
				end else if (h_area <= NDX_LAST_DROP) begin
					r_next.rd_data = r_reg.mem[word_index(h_area, h_reg)];
				end else begin
					r_next.rd_data = 16'h0000;
				end
			end else if (h_area == 6'h00 && h_reg == REG_DROP_DEPTH) begin
				r_next.depth_raw = host_wdata[DEPTH_VAL_W-1:0];
				if (r_reg.is_master) begin
					r_next.depth_done = 1'b1;
				end else begin
					r_next.depth_done = 1'b0;
					r_next.depth_pend = 1'b1;
				end
			end else if (h_area == 6'h00) begin
				if (r_reg.is_master && h_reg >= REG_BCAST_FIRST && h_reg <= REG_BCAST_LAST) begin
					r_next.mem[word_index(h_area, h_reg)] = host_wdata;
				end else begin
					r_next.refused = 1'b1;
				end
			end else if (h_area <= NDX_LAST_DROP && h_reg <= SLAVE_LAST_IDX) begin
				if (!r_reg.is_master && owned(h_area, r_reg.own_drop,
						r_reg.depth_act, r_reg.depth_def)) begin
					r_next.mem[word_index(h_area, h_reg)] = host_wdata;
				end else begin
					r_next.refused = 1'b1;
				end
			end else if (h_area <= NDX_LAST_DROP) begin
				if (r_reg.is_master) begin
					r_next.mem[word_index(h_area, h_reg)] = host_wdata;
				end else begin
					r_next.refused = 1'b1;
				end
			end else begin
				r_next.refused = 1'b1;
			end
		end

		// Link word handshake into the buffer
		if (buf_ready) begin
			r_next.seq_valid = 1'b0;
		end

		unique case (r_reg.st)
			NDX_ST_IDLE: begin
				if (!r_reg.captured) begin
					r_next.st = NDX_ST_IDLE;
				end else if (!r_reg.is_master) begin
					if (rx_valid && rx_poll && owned(x_area, r_reg.own_drop,
							r_reg.depth_act, r_reg.depth_def)) begin
						r_next.st   = NDX_ST_SEND;
						r_next.drop = x_area;
						r_next.idx  = 6'h00;
					end
				end else if (r_reg.drop > NDX_LAST_DROP || r_reg.drop == 6'h00) begin
					// End of one update cycle
					r_next.drop   = NDX_FIRST_DROP;
					r_next.probed = 1'b0;
					if (!r_reg.probed) begin
						r_next.last_probe = 6'h00;
					end
					if (term_msg) begin
						r_next.st       = NDX_ST_WAIT;
						r_next.msg_wait = 1'b1;
						r_next.timer    = TIMER_W'(MSG_WAIT - 1);
					end
				end else if (r_reg.active[r_reg.drop]) begin
					r_next.st  = NDX_ST_SEND;
					r_next.idx = 6'h00;
				end else if (!r_reg.probed && r_reg.drop > r_reg.last_probe) begin
					r_next.st         = NDX_ST_SEND;
					r_next.idx        = POLL_IDX;
					r_next.probed     = 1'b1;
					r_next.last_probe = r_reg.drop;
				end else begin
					r_next.drop = r_reg.drop + 6'h01;
				end
			end
			NDX_ST_SEND: begin
				if (!r_reg.seq_valid || buf_ready) begin
					r_next.seq_valid = 1'b1;
					r_next.idx       = r_reg.idx + 6'h01;
					if (!r_reg.is_master) begin
						w_area = r_reg.drop;
						w_reg  = r_reg.idx;
						last   = r_reg.idx == SLAVE_LAST_IDX;
					end else if (r_reg.idx < BCAST_WORDS) begin
						w_area = 6'h00;
						w_reg  = REG_BCAST_FIRST + r_reg.idx;
					end else if (r_reg.idx < POLL_IDX) begin
						w_area = r_reg.drop;
						w_reg  = REG_UPPER_FIRST + r_reg.idx - BCAST_WORDS;
					end else begin
						w_area = r_reg.drop;
						last   = 1'b1;
					end
					r_next.seq_word = {last && r_reg.is_master, word_index(w_area, w_reg),
						(last && r_reg.is_master) ? 16'h0000 : r_reg.mem[word_index(w_area, w_reg)]};
					if (last) begin
						r_next.st    = r_reg.is_master ? NDX_ST_WAIT : NDX_ST_IDLE;
						r_next.timer = probe ? TIMER_W'(PROBE_WAIT - 1)
							: TIMER_W'(DROP_WAIT - 1);
					end
				end
			end
			NDX_ST_WAIT: begin
				if (r_reg.timer != '0) begin
					r_next.timer = r_reg.timer - TIMER_W'(1);
				end else begin
					r_next.st       = NDX_ST_IDLE;
					r_next.msg_wait = 1'b0;
					if (!r_reg.msg_wait) begin
						// Drop is active when any lower word for it came back since the end of its previous slot
						r_next.active[r_reg.drop] = r_reg.heard[r_reg.drop] ||
							(x_hit && x_area == r_reg.drop);
						r_next.heard[r_reg.drop]  = 1'b0;
						r_next.drop               = r_reg.drop + 6'h01;
					end
				end
			end
			default: begin
				r_next.st = NDX_ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			r_reg            <= '0;
			r_reg.depth_raw  <= DEPTH_RESET;
			r_reg.depth_done <= DONE_RESET;
			r_reg.drop       <= NDX_FIRST_DROP;
		end else begin
			r_reg <= r_next;
		end
	end

	ndx_pair_buffer #(
		.WIDTH (TX_W),
		.DEPTH (2)
	) u_tx_buffer (
		.clock     (clock),
		.rst_n     (rst_n),
		.in_valid  (r_reg.seq_valid),
		.in_ready  (buf_ready),
		.in_data   (r_reg.seq_word),
		.out_valid (tx_valid),
		.out_ready (tx_ready),
		.out_data  (buf_word)
	);

	assign tx_poll      = buf_word[TX_W-1];
	assign tx_addr      = buf_word[TX_W-2:NDX_DATA_W];
	assign tx_data      = buf_word[NDX_DATA_W-1:0];
	assign host_rdata   = r_reg.rd_data;
	assign host_ack     = r_reg.ack;
	assign host_refused = r_reg.refused;

endmodule

// ### src/ndx_pkg.sv
/*
 * Constants and types shared by the network drop data exchange block.
 * Assumes a 100 MHz clock and a 12-bit word address of {drop area, register}.
 */
package ndx_pkg;

	// Memory image geometry
	localparam int          NDX_DROPS      = 56;
	localparam int          NDX_AREA_REGS  = 64;
	localparam int          NDX_WORDS      = NDX_DROPS * NDX_AREA_REGS;
	localparam int          NDX_ADDR_W     = 12;
	localparam int          NDX_DATA_W     = 16;
	localparam logic [5:0]  NDX_LAST_DROP  = 6'h37;
	localparam logic [5:0]  NDX_FIRST_DROP = 6'h01;

	// Register offsets inside the drop 0 area
	localparam logic [5:0]  REG_DROP_NUMBER = 6'h0c;
	localparam logic [5:0]  REG_DROP_DEPTH  = 6'h14;
	localparam logic [5:0]  REG_BCAST_FIRST = 6'h20;
	localparam logic [5:0]  REG_BCAST_LAST  = 6'h27;

	// Split of each drop area: slave-written lower half, master-written upper half
	localparam logic [5:0]  REG_UPPER_FIRST = 6'h20;
	localparam logic [5:0]  SLAVE_LAST_IDX  = 6'h1f;

	// Drop depth register layout and limits
	localparam int          DEPTH_VAL_W    = 14;
	localparam int          DEPTH_ERR_BIT  = 14;
	localparam int          DEPTH_DONE_BIT = 15;
	localparam logic [13:0] DEPTH_MIN      = 14'h0001;
	localparam logic [13:0] DROP_LIMIT     = 14'h0038;
	localparam logic [13:0] DEPTH_RESET    = 14'h0001;
	localparam logic        DONE_RESET     = 1'b1;

	// Master send sequence: 8 broadcast words, 32 upper words, then the poll
	localparam logic [5:0]  BCAST_WORDS = 6'h08;
	localparam logic [5:0]  POLL_IDX    = 6'h28;

	// Timing
	localparam int CLK_PERIOD_NS     = 10;
	localparam int DROP_TIME_NS      = 2990000;
	localparam int NEW_DROP_TIME_NS  = 2480000;
	localparam int MSG_MASTER_NS     = 2090000;
	localparam int DROP_CYCLES       = DROP_TIME_NS / CLK_PERIOD_NS;
	localparam int NEW_DROP_CYCLES   = NEW_DROP_TIME_NS / CLK_PERIOD_NS;
	localparam int MSG_MASTER_CYCLES = MSG_MASTER_NS / CLK_PERIOD_NS;
	localparam int TIMER_W           = 20;

	// Strap capture waits for the pin synchronisers to fill
	localparam logic [1:0] BOOT_DONE = 2'h3;

	// Link word: {poll, address, data}
	localparam int TX_W = 1 + NDX_ADDR_W + NDX_DATA_W;

	typedef enum logic [1:0] {
		NDX_ST_IDLE = 2'b00,
		NDX_ST_SEND = 2'b01,
		NDX_ST_WAIT = 2'b11
	} ndx_state_t;

endpackage

// ### src/ndx_pair_buffer.sv
/*
 * Small shifting FIFO between the send sequencer and the link.
 * Assumes the consumer may hold out_ready low for any time.
 */
`timescale 1ns/1ps
module ndx_pair_buffer #(
	parameter int WIDTH = 29,
	parameter int DEPTH = 2
) (
	input  wire logic             clock,
	input  wire logic             rst_n,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);

	typedef struct packed {
		logic [DEPTH-1:0]            vld;
		logic [DEPTH-1:0][WIDTH-1:0] slot;
	} ndx_buf_state_t;

	ndx_buf_state_t r_reg;
	ndx_buf_state_t r_next;

	always_comb begin
		logic placed;
		placed = 1'b0;
		r_next = r_reg;
		// Head leaves, rest shift down
		if (r_reg.vld[0] && out_ready) begin
			for (int i = 0; i < DEPTH - 1; i++) begin
				r_next.slot[i] = r_reg.slot[i+1];
				r_next.vld[i]  = r_reg.vld[i+1];
			end
			r_next.vld[DEPTH-1] = 1'b0;
		end
		// New word takes the first free slot
		if (in_valid && !r_reg.vld[DEPTH-1]) begin
			for (int i = 0; i < DEPTH; i++) begin
				if (!placed && !r_next.vld[i]) begin
					r_next.slot[i] = in_data;
					r_next.vld[i]  = 1'b1;
					placed         = 1'b1;
				end
			end
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

	assign in_ready  = !r_reg.vld[DEPTH-1];
	assign out_valid = r_reg.vld[0];
	assign out_data  = r_reg.slot[0];

endmodule

// ### verif/ndx_exchange_checker.sv
/* Checker of the host port and link words of the exchange block.
 Assumes straps held steady from reset onwards. */
`timescale 1ns/1ps
module ndx_exchange_checker import ndx_pkg::*; (
	input wire logic                  clock,
	input wire logic                  rst_n,
	input wire logic                  master_pin,
	input wire logic                  host_en,
	input wire logic                  host_we,
	input wire logic [NDX_ADDR_W-1:0] host_addr,
	input wire logic                  host_ack,
	input wire logic                  host_refused,
	input wire logic                  tx_valid,
	input wire logic                  tx_ready,
	input wire logic                  tx_poll,
	input wire logic [NDX_ADDR_W-1:0] tx_addr,
	input wire logic [NDX_DATA_W-1:0] tx_data
);
	logic wr;
	logic mid;
	logic bc;
	assign wr  = host_en && host_we;
	assign mid = host_addr[11:6] >= 6'h01 && host_addr[11:6] <= 6'h37;
	assign bc  = host_addr[11:6] == 6'h00 && host_addr[5:3] == 3'h4;
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);
	ack_one_cycle_a: assert property (host_en |=> host_ack)
		else $error("host ack missing");
	ack_only_en_a: assert property (!host_en |=> !host_ack && !host_refused)
		else $error("host ack without request");
	slave_bcast_ro_a: assert property (!master_pin && wr && bc |=> host_refused)
		else $error("slave broadcast write taken");
	master_bcast_rw_a: assert property (master_pin && wr && bc |=> !host_refused)
		else $error("master broadcast write refused");
	master_lower_ro_a: assert property (master_pin && wr && mid && !host_addr[5]
		|=> host_refused)
		else $error("master lower write taken");
	slave_upper_ro_a: assert property (!master_pin && wr && mid && host_addr[5]
		|=> host_refused)
		else $error("slave upper write taken");
	master_upper_rw_a: assert property (master_pin && wr && mid && host_addr[5]
		|=> !host_refused)
		else $error("master upper write refused");
	depth_write_ok_a: assert property (wr && host_addr == 12'h014 |=> !host_refused)
		else $error("depth write refused");
	high_area_a: assert property (wr && host_addr[11:6] > 6'h37 |=> host_refused)
		else $error("write above area 55 taken");
	tx_hold_a: assert property (tx_valid && !tx_ready
		|=> tx_valid && $stable({tx_poll, tx_addr, tx_data}))
		else $error("link word changed while held");
	poll_zero_a: assert property (tx_valid && tx_poll
		|-> tx_data == 16'h0000 && tx_addr[5:0] == 6'h00)
		else $error("poll word malformed");
	slave_lower_a: assert property (!master_pin && tx_valid
		|-> !tx_poll && tx_addr[5:0] < 6'h20)
		else $error("slave sent a non-lower word");
	refused_cov: cover property (wr ##1 host_refused);
	slave_send_cov: cover property (!master_pin && tx_valid && tx_ready);
	master_poll_cov: cover property (master_pin && tx_valid && tx_poll && tx_ready);
endmodule
bind ndx_exchange ndx_exchange_checker chk_i (.clock, .rst_n, .master_pin, .host_en,
	.host_we, .host_addr, .host_ack, .host_refused, .tx_valid, .tx_ready, .tx_poll,
	.tx_addr, .tx_data);

// ### verif/ndx_far_model.sv
/* Remote module on the link: sends words on command, takes words, may stall.
 Assumes the block's clock and commands from the bench. */
`timescale 1ns/1ps
module ndx_far_model (
	input  wire logic        clock,
	input  wire logic        rst_n,
	input  wire logic        stall,
	input  wire logic        send,
	input  wire logic        s_poll,
	input  wire logic [11:0] s_addr,
	input  wire logic [15:0] s_data,
	output logic             rx_valid,
	output logic             rx_poll,
	output logic [11:0]      rx_addr,
	output logic [15:0]      rx_data,
	output logic             tx_ready
);
	always @(posedge clock) begin
		rx_valid <= rst_n && send;
		rx_poll  <= send && s_poll;
		// Idle lines change every cycle
		{rx_addr, rx_data} <= !rst_n ? 28'h0 : send ? {s_addr, s_data} : ~{rx_addr, rx_data};
		tx_ready <= !rst_n || !stall || !tx_ready;
	end
endmodule

// ### verif/ndx_exchange_tb_top.sv
/* Self-checking bench of the exchange block with a remote module model.
 Assumes shortened wait parameters and straps applied during reset. */
`timescale 1ns/1ps
module ndx_exchange_tb_top import ndx_pkg::*;;
	logic        clock = 0, rst_n = 0, master_pin = 0, term_msg = 0, host_en = 0;
	logic        host_we = 0, send = 0, s_poll = 0, stall = 0, found;
	logic [5:0]  drop_switch = 6'h05;
	logic [11:0] host_addr = 12'h000, s_addr = 12'h000, rx_addr, tx_addr;
	logic [15:0] host_wdata = 16'h0000, s_data = 16'h0000, host_rdata, rx_data, tx_data;
	logic        host_ack, host_refused, rx_valid, rx_poll, tx_valid, tx_ready, tx_poll;
	logic [28:0] txq[$];
	int          n_mismatch = 0, checks = 0;
	always #5 clock = ~clock;
	ndx_exchange #(.DROP_WAIT(20), .PROBE_WAIT(15), .MSG_WAIT(10)) dut (.clock, .rst_n,
		.master_pin, .drop_switch, .term_msg, .host_en, .host_we, .host_addr, .host_wdata,
		.host_rdata, .host_ack, .host_refused, .rx_valid, .rx_poll, .rx_addr, .rx_data,
		.tx_valid, .tx_ready, .tx_poll, .tx_addr, .tx_data);
	ndx_far_model far (.clock, .rst_n, .stall, .send, .s_poll, .s_addr, .s_data,
		.rx_valid, .rx_poll, .rx_addr, .rx_data, .tx_ready);
	always @(posedge clock) if (tx_valid && tx_ready) txq.push_back({tx_poll, tx_addr, tx_data});
	task chk(string n, logic [28:0] e, logic [28:0] g);
		checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask
	task test_done;
		$display("checks %0d n_mismatch %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task do_reset(logic m, logic [5:0] d);
		@(posedge clock);
		rst_n <= 1'b0;
		master_pin <= m;
		drop_switch <= d;
		repeat (10) @(posedge clock);
		rst_n <= 1'b1;
		repeat (6) @(posedge clock);
		txq.delete();
	endtask
	task hw(logic [11:0] a, logic [15:0] d, logic r);
		@(posedge clock);
		{host_en, host_we, host_addr, host_wdata} <= {2'b11, a, d};
		@(posedge clock);
		host_en <= 1'b0;
		#1 chk("ack_refused", {27'h0, 1'b1, r}, {27'h0, host_ack, host_refused});
	endtask
	task hr(logic [11:0] a, logic [15:0] e);
		@(posedge clock);
		{host_en, host_we, host_addr} <= {2'b10, a};
		@(posedge clock);
		host_en <= 1'b0;
		#1 chk("ack_rdata", {12'h0, 1'b1, e}, {12'h0, host_ack, host_rdata});
	endtask
	task rx_word(logic p, logic [11:0] a, logic [15:0] d);
		@(posedge clock);
		{send, s_poll, s_addr, s_data} <= {1'b1, p, a, d};
		@(posedge clock);
		send <= 1'b0;
		repeat (2) @(posedge clock);
	endtask
	task wait_q(int n);
		for (int i = 0; i < 3000 && txq.size() < n; i++) @(posedge clock);
	endtask
	task t_power_up;
		hr(12'h014, 16'h8001);
		hr(12'h00c, 16'h0005);
		hw(12'h140, 16'hbeef, 1'b0);
		hw(12'h180, 16'h0001, 1'b1);
		$display("test power_up done");
	endtask
	task t_depth;
		hw(12'h014, 16'h0034, 1'b0);
		hr(12'h014, 16'hc034);
		hw(12'h014, 16'h0033, 1'b0);
		hr(12'h014, 16'h8033);
		hw(12'h014, 16'hc002, 1'b0);
		hr(12'h014, 16'h8002);
		hw(12'h014, 16'h0000, 1'b0);
		hr(12'h014, 16'hc000);
		hw(12'h181, 16'h1111, 1'b0);
		hw(12'h1c0, 16'h1111, 1'b1);
		hw(12'h100, 16'h2222, 1'b1);
		hw(12'h160, 16'h3333, 1'b1);
		hw(12'h021, 16'h4444, 1'b1);
		hw(12'he00, 16'h5555, 1'b1);
		hr(12'he00, 16'h0000);
		$display("test depth done");
	endtask
	task t_rx_image;
		rx_word(1'b0, 12'h243, 16'h5a5a);
		hr(12'h243, 16'h5a5a);
		rx_word(1'b0, 12'h021, 16'h0f0f);
		hr(12'h021, 16'h0f0f);
		rx_word(1'b0, 12'h140, 16'h0bad);
		hr(12'h140, 16'hbeef);
		$display("test rx_image done");
	endtask
	task t_slave_poll;
		stall <= 1'b1;
		txq.delete();
		rx_word(1'b1, 12'h140, 16'h0000);
		wait_q(33);
		chk("count", 29'h20, 29'(txq.size()));
		chk("first", {1'b0, 12'h140, 16'hbeef}, txq[0]);
		chk("last_addr", {17'h0, 12'h15f}, {17'h0, txq[31][27:16]});
		stall <= 1'b0;
		$display("test slave_poll done");
	endtask
	task t_master;
		do_reset(1'b1, 6'h00);
		hw(12'h020, 16'h1234, 1'b0);
		hw(12'h060, 16'h4321, 1'b0);
		hw(12'h040, 16'h7777, 1'b1);
		hw(12'h014, 16'h0000, 1'b0);
		hr(12'h014, 16'h8000);
		stall <= 1'b1;
		txq.delete();
		found = 1'b0;
		for (int i = 0; i < 5000 && !found; i++) begin
			@(posedge clock);
			found = txq.size() > 0 && txq[$] === {1'b1, 12'h040, 16'h0000};
		end
		chk("probe_found", 29'h1, {28'h0, found});
		rx_word(1'b0, 12'h040, 16'h0001);
		txq.delete();
		wait_q(41);
		chk("bcast", {1'b0, 12'h020, 16'h1234}, txq[0]);
		chk("upper", {1'b0, 12'h060, 16'h4321}, txq[8]);
		chk("poll", {1'b1, 12'h040, 16'h0000}, txq[40]);
		stall <= 1'b0;
		$display("test master done");
	endtask
	initial begin
		do_reset(1'b0, 6'h05);
		t_power_up;
		t_depth;
		t_rx_image;
		t_slave_poll;
		t_master;
		test_done;
	end
	initial begin
		repeat (20000) @(posedge clock);
		n_mismatch++;
		test_done;
	end
endmodule
